// ===== rtl/uri_pkg.sv
// Purpose: Shared constants and types of the serial port register block.
// Assumes: 200 MHz system clock, byte offsets on a 12-bit register address.
// Notes: Event bit positions match the interrupt mask layout.
package uri_pkg;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h300;
   localparam logic [11:0] OFF_IRQ_SET = 12'h304;
   localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
   localparam logic [11:0] OFF_ERR_CAUSE = 12'h480;
   localparam logic [11:0] OFF_PORT_EN = 12'h500;
   localparam logic [11:0] OFF_HS_OUT_PIN = 12'h508;
   localparam logic [11:0] OFF_SER_OUT_PIN = 12'h50C;
   localparam logic [11:0] OFF_HS_IN_PIN = 12'h510;
   localparam logic [11:0] OFF_SER_IN_PIN = 12'h514;
   localparam logic [11:0] OFF_RX_BYTE = 12'h518;
   localparam logic [11:0] OFF_TX_BYTE = 12'h51C;
   localparam logic [11:0] OFF_LINE_RATE = 12'h524;
   localparam logic [11:0] OFF_LINE_SETUP = 12'h56C;
   localparam logic [11:0] OFF_EVT_STAT = 12'h600;
   // Event positions, shared by the mask and the event status word.
   localparam int EV_CTS = 0;
   localparam int EV_CLEAR_TO_SEND_DROPPED = 1;
   localparam int EV_RX_RDY = 2;
   localparam int EV_TX_DONE = 7;
   localparam int EV_ERR = 9;
   localparam int EV_RX_TMO = 17;
   localparam logic [31:0] EV_MASK = 32'h0002_0287;
   // Error cause positions.
   localparam int ERR_OVR = 0;
   localparam int ERR_PAR = 1;
   localparam int ERR_FRM = 2;
   localparam int ERR_BRK = 3;
   localparam logic [2:0] EN_ON = 3'h4;
   localparam logic [31:0] PIN_NONE = 32'hFFFF_FFFF;
   localparam logic [31:0] PIN_COUNT = 32'h0000_0020;
   localparam logic [31:0] RATE_RST = 32'h0400_0000;
   localparam logic [2:0] PAR_ON = 3'h7;
   localparam logic [2:0] FIFO_DEPTH = 3'h6;
   localparam logic [2:0] FIFO_LAST = 3'h5;
   // Handshake drops once only four free places remain.
   localparam logic [2:0] FIFO_HOLD = 3'h2;
   // Rate codes are fractions of a 16 MHz reference scaled by 2^32.
   localparam int CLK_HZ = 200_000_000;
   localparam int REF_HZ = 16_000_000;
   localparam logic [36:0] RATE_MOD = 37'(2 * CLK_HZ / REF_HZ) << 31;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID = 4'h7;

   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uri_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BRK, RX_WAIT} uri_rx_e;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } uri_bus_s;

   typedef struct packed {
      logic [31:0] drv;
      logic [31:0] oe;
   } uri_pins_s;
endpackage

// ===== rtl/uri_rate_gen.sv
// Purpose: Oversampling tick generator, sixteen ticks per line bit.
// Assumes: Rate code is a fraction of the reference scaled by 2^32.
// Notes: Fractional accumulation keeps long-term rate exact.
`timescale 1ns/10ps
module uri_rate_gen (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic run_in,
   input wire logic [31:0] rate_in,
   output logic tick_out
);
   typedef struct packed {
      logic [36:0] acc;
      logic tick;
   } uri_gen_s;

   uri_gen_s s;
   uri_gen_s n;
   logic [36:0] sum;

   always_comb begin
      n = s;
      sum = s.acc + {1'b0, rate_in, 4'h0};
      n.tick = 1'b0;
      if (!run_in) begin
         n.acc = '0;
      end else if (sum >= uri_pkg::RATE_MOD) begin
         n.acc = sum - uri_pkg::RATE_MOD;
         n.tick = 1'b1;
      end else begin
         n.acc = sum;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tick_out = s.tick;
endmodule

// ===== rtl/uri_top.sv
// Purpose: Register block, transmitter and receiver of an async serial port.
// Assumes: Pins are synchronous to clk_sys_in; 32 selectable pins.
// Notes: A disabled port drives no pin and ignores the line.
`timescale 1ns/10ps
module uri_top (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire uri_pkg::uri_bus_s bus_in,
   output logic [31:0] rdata_out,
   input wire logic [31:0] pin_in,
   output uri_pkg::uri_pins_s pins_out,
   output logic irq_out
);
   typedef struct packed {
      logic [31:0] mask;
      logic [31:0] evt;
      logic [3:0] err;
      logic [2:0] en;
      logic [31:0] pin_rts;
      logic [31:0] pin_txd;
      logic [31:0] pin_cts;
      logic [31:0] pin_rxd;
      logic [31:0] rate;
      logic handshake_gate;
      logic [2:0] par;
      logic [31:0] rdata;
      logic [7:0] txb;
      logic tx_pend;
      uri_pkg::uri_tx_e tx_st;
      logic [8:0] tx_sh;
      logic [3:0] tx_cnt;
      logic [3:0] tx_bit;
      logic txl;
      uri_pkg::uri_rx_e rx_st;
      logic [7:0] rx_sh;
      logic [3:0] rx_cnt;
      logic [3:0] rx_bit;
      logic rx_pe;
      logic [5:0][7:0] mem;
      logic [2:0] wp;
      logic [2:0] rp;
      logic [2:0] cnt;
      logic [7:0] rxb;
      logic rxb_full;
      logic cts_d;
      logic rts_n;
   } uri_state_s;

   uri_state_s s;
   uri_state_s n;
   logic tick;
   logic on;
   logic par_on;
   logic rx_in;
   logic cts_n;
   logic [3:0] nb;
   logic [31:0] ev_set;
   logic [31:0] ev_clr;
   logic push;
   logic pop;
   logic tx_end;
   logic rx_end;

   function automatic logic pin_ok(input logic [31:0] sel);
      pin_ok = sel < uri_pkg::PIN_COUNT;
   endfunction

   function automatic logic [2:0] idx_nxt(input logic [2:0] i);
      idx_nxt = (i == uri_pkg::FIFO_LAST) ? 3'h0 : i + 3'h1;
   endfunction

   function automatic logic is_wr(input uri_pkg::uri_bus_s b, input logic [11:0] a);
      is_wr = b.wr && b.addr == a;
   endfunction

   uri_rate_gen u_rate (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .run_in(on),
      .rate_in(s.rate),
      .tick_out(tick)
   );

   assign on = s.en == uri_pkg::EN_ON;
   assign par_on = s.par == uri_pkg::PAR_ON;
   assign nb = par_on ? 4'h9 : 4'h8;
   // An idle-high level stands in for an unconnected or disabled receive line.
   assign rx_in = (on && pin_ok(s.pin_rxd)) ? pin_in[s.pin_rxd[4:0]] : 1'b1;
   // Without flow control, or with no handshake pin, sending is always allowed.
   assign cts_n = s.handshake_gate && on && pin_ok(s.pin_cts) && pin_in[s.pin_cts[4:0]];
   assign tx_end = tick && s.tx_cnt == uri_pkg::OVS_LAST;
   assign rx_end = tick && s.rx_cnt == uri_pkg::OVS_LAST;

   always_comb begin
      n = s;
      ev_set = '0;
      ev_clr = '0;
      push = 1'b0;
      pop = 1'b0;
      n.rdata = '0;
      // Register writes.
      if (bus_in.wr) begin
         case (bus_in.addr)
            uri_pkg::OFF_IRQ_MASK: n.mask = bus_in.wdata & uri_pkg::EV_MASK;
            uri_pkg::OFF_IRQ_SET: n.mask = s.mask | (bus_in.wdata & uri_pkg::EV_MASK);
            uri_pkg::OFF_IRQ_CLR: n.mask = s.mask & ~bus_in.wdata;
            uri_pkg::OFF_PORT_EN: n.en = bus_in.wdata[2:0];
            uri_pkg::OFF_HS_OUT_PIN: n.pin_rts = bus_in.wdata;
            uri_pkg::OFF_SER_OUT_PIN: n.pin_txd = bus_in.wdata;
            uri_pkg::OFF_HS_IN_PIN: n.pin_cts = bus_in.wdata;
            uri_pkg::OFF_SER_IN_PIN: n.pin_rxd = bus_in.wdata;
            uri_pkg::OFF_TX_BYTE: begin
               n.txb = bus_in.wdata[7:0];
               n.tx_pend = 1'b1;
            end
            uri_pkg::OFF_LINE_RATE: n.rate = bus_in.wdata;
            uri_pkg::OFF_LINE_SETUP: begin
               n.handshake_gate = bus_in.wdata[0];
               n.par = bus_in.wdata[3:1];
            end
            uri_pkg::OFF_EVT_STAT: ev_clr = bus_in.wdata;
            default: ;
         endcase
      end
      // Register reads; data stand only in the cycle after the strobe.
      if (bus_in.rd) begin
         case (bus_in.addr)
            uri_pkg::OFF_IRQ_MASK: n.rdata = s.mask;
            uri_pkg::OFF_IRQ_SET: n.rdata = s.mask;
            uri_pkg::OFF_IRQ_CLR: n.rdata = s.mask;
            uri_pkg::OFF_ERR_CAUSE: n.rdata = {28'h0, s.err};
            uri_pkg::OFF_PORT_EN: n.rdata = {29'h0, s.en};
            uri_pkg::OFF_HS_OUT_PIN: n.rdata = s.pin_rts;
            uri_pkg::OFF_SER_OUT_PIN: n.rdata = s.pin_txd;
            uri_pkg::OFF_HS_IN_PIN: n.rdata = s.pin_cts;
            uri_pkg::OFF_SER_IN_PIN: n.rdata = s.pin_rxd;
            uri_pkg::OFF_RX_BYTE: begin
               n.rdata = {24'h0, s.rxb};
               n.rxb_full = 1'b0;
            end
            uri_pkg::OFF_TX_BYTE: n.rdata = {24'h0, s.txb};
            uri_pkg::OFF_LINE_RATE: n.rdata = s.rate;
            uri_pkg::OFF_LINE_SETUP: n.rdata = {28'h0, s.par, s.handshake_gate};
            uri_pkg::OFF_EVT_STAT: n.rdata = s.evt;
            default: n.rdata = '0;
         endcase
      end
      // Error causes clear on written ones; new errors below win.
      if (is_wr(bus_in, uri_pkg::OFF_ERR_CAUSE)) begin
         n.err = s.err & ~bus_in.wdata[3:0];
      end
      // Handshake input edges.
      n.cts_d = cts_n;
      ev_set[uri_pkg::EV_CTS] = s.cts_d && !cts_n;
      ev_set[uri_pkg::EV_CLEAR_TO_SEND_DROPPED] = !s.cts_d && cts_n;
      // Transmitter.
      if (s.tx_st != uri_pkg::TX_IDLE) begin
         n.tx_cnt = tick ? s.tx_cnt + 4'h1 : s.tx_cnt;
      end
      case (s.tx_st)
         uri_pkg::TX_IDLE: begin
            n.txl = 1'b1;
            n.tx_cnt = 4'h0;
            n.tx_bit = 4'h0;
            if (on && s.tx_pend && !cts_n) begin
               n.tx_pend = is_wr(bus_in, uri_pkg::OFF_TX_BYTE);
               n.tx_sh = {par_on & ^s.txb, s.txb};
               n.txl = 1'b0;
               n.tx_st = uri_pkg::TX_START;
            end
         end
         uri_pkg::TX_START: begin
            if (tx_end) begin
               n.txl = s.tx_sh[0];
               n.tx_st = uri_pkg::TX_DATA;
            end
         end
         uri_pkg::TX_DATA: begin
            if (tx_end) begin
               if (s.tx_bit == nb - 4'h1) begin
                  n.txl = 1'b1;
                  n.tx_st = uri_pkg::TX_STOP;
               end else begin
                  n.tx_bit = s.tx_bit + 4'h1;
                  n.tx_sh = s.tx_sh >> 1;
                  n.txl = s.tx_sh[1];
               end
            end
         end
         uri_pkg::TX_STOP: begin
            if (tx_end) begin
               ev_set[uri_pkg::EV_TX_DONE] = 1'b1;
               n.tx_st = uri_pkg::TX_IDLE;
            end
         end
         default: n.tx_st = uri_pkg::TX_IDLE;
      endcase
      // Receiver, sampling each bit in its middle.
      n.rx_cnt = tick ? s.rx_cnt + 4'h1 : s.rx_cnt;
      case (s.rx_st)
         uri_pkg::RX_IDLE: begin
            n.rx_cnt = 4'h0;
            if (!rx_in) begin
               n.rx_st = uri_pkg::RX_START;
            end
         end
         uri_pkg::RX_START: begin
            if (tick && s.rx_cnt == uri_pkg::OVS_MID) begin
               n.rx_cnt = 4'h0;
               n.rx_bit = 4'h0;
               n.rx_pe = 1'b0;
               n.rx_st = rx_in ? uri_pkg::RX_IDLE : uri_pkg::RX_DATA;
            end
         end
         uri_pkg::RX_DATA: begin
            if (rx_end) begin
               if (s.rx_bit < 4'h8) begin
                  n.rx_sh = {rx_in, s.rx_sh[7:1]};
               end else begin
                  n.rx_pe = rx_in != ^s.rx_sh;
               end
               n.rx_bit = s.rx_bit + 4'h1;
               if (s.rx_bit == nb - 4'h1) begin
                  n.rx_st = uri_pkg::RX_STOP;
               end
            end
         end
         uri_pkg::RX_STOP: begin
            if (rx_end) begin
               if (rx_in) begin
                  push = 1'b1;
                  n.rx_st = uri_pkg::RX_IDLE;
                  if (s.rx_pe) begin
                     n.err[uri_pkg::ERR_PAR] = 1'b1;
                  end
               end else begin
                  n.err[uri_pkg::ERR_FRM] = 1'b1;
                  n.rx_st = (s.rx_sh == 8'h00) ? uri_pkg::RX_BRK : uri_pkg::RX_WAIT;
               end
            end
         end
         uri_pkg::RX_BRK: begin
            // Line low for a whole frame and one more bit time is a break.
            if (rx_in) begin
               n.rx_st = uri_pkg::RX_IDLE;
            end else if (rx_end) begin
               n.err[uri_pkg::ERR_BRK] = 1'b1;
               n.rx_st = uri_pkg::RX_WAIT;
            end
         end
         uri_pkg::RX_WAIT: begin
            if (rx_in) begin
               n.rx_st = uri_pkg::RX_IDLE;
            end
         end
         default: n.rx_st = uri_pkg::RX_IDLE;
      endcase
      // Receive FIFO ahead of the receive register.
      if (push) begin
         if (s.cnt == uri_pkg::FIFO_DEPTH) begin
            n.err[uri_pkg::ERR_OVR] = 1'b1;
            push = 1'b0;
         end else begin
            n.mem[s.wp] = s.rx_sh;
            n.wp = idx_nxt(s.wp);
         end
      end
      if (!n.rxb_full && s.cnt != 3'h0) begin
         pop = 1'b1;
         n.rxb = s.mem[s.rp];
         n.rxb_full = 1'b1;
         n.rp = idx_nxt(s.rp);
         ev_set[uri_pkg::EV_RX_RDY] = 1'b1;
      end
      n.cnt = s.cnt + {2'h0, push} - {2'h0, pop};
      // Handshake out drops early and returns only once the FIFO is empty.
      if (!s.handshake_gate) begin
         n.rts_n = 1'b0;
      end else if (n.cnt >= uri_pkg::FIFO_HOLD) begin
         n.rts_n = 1'b1;
      end else if (n.cnt == 3'h0) begin
         n.rts_n = 1'b0;
      end
      ev_set[uri_pkg::EV_ERR] = |(n.err & ~s.err);
      if (!on) begin
         n.tx_st = uri_pkg::TX_IDLE;
         n.rx_st = uri_pkg::RX_IDLE;
         n.txl = 1'b1;
      end
      // A clear meeting a new event loses, so no event is dropped.
      n.evt = ((s.evt & ~ev_clr) | ev_set) & uri_pkg::EV_MASK;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         s <= '0;
         s.pin_rts <= uri_pkg::PIN_NONE;
         s.pin_txd <= uri_pkg::PIN_NONE;
         s.pin_cts <= uri_pkg::PIN_NONE;
         s.pin_rxd <= uri_pkg::PIN_NONE;
         s.rate <= uri_pkg::RATE_RST;
         s.txl <= 1'b1;
      end else begin
         s <= n;
      end
   end

   always_comb begin
      pins_out = '0;
      if (on && pin_ok(s.pin_rts)) begin
         pins_out.drv[s.pin_rts[4:0]] = s.rts_n;
         pins_out.oe[s.pin_rts[4:0]] = 1'b1;
      end
      if (on && pin_ok(s.pin_txd)) begin
         pins_out.drv[s.pin_txd[4:0]] = s.txl;
         pins_out.oe[s.pin_txd[4:0]] = 1'b1;
      end
   end

   assign rdata_out = s.rdata;
   assign irq_out = |(s.evt & s.mask);

   set_mask_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      is_wr(bus_in, uri_pkg::OFF_IRQ_SET) |=>
      ((s.mask & $past(bus_in.wdata) & uri_pkg::EV_MASK) == ($past(bus_in.wdata) & uri_pkg::EV_MASK)))
      else $error("Mask set write lost a bit.");
   clr_mask_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      is_wr(bus_in, uri_pkg::OFF_IRQ_CLR) |=> (s.mask & $past(bus_in.wdata)) == 32'h0)
      else $error("Mask clear write left a bit set.");
   err_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s.err[uri_pkg::ERR_FRM] && !(is_wr(bus_in, uri_pkg::OFF_ERR_CAUSE) && bus_in.wdata[2])
      |=> s.err[uri_pkg::ERR_FRM])
      else $error("Framing flag cleared without a write of one.");
   tx_load_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      is_wr(bus_in, uri_pkg::OFF_TX_BYTE) |=> s.tx_pend && s.txb == $past(bus_in.wdata[7:0]))
      else $error("Transmit byte not taken.");
   pin_free_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      !on || (s.pin_txd == uri_pkg::PIN_NONE && s.pin_rts == uri_pkg::PIN_NONE)
      |=> pins_out.oe == 32'h0 || $past(bus_in.wr))
      else $error("A pin is driven while disabled or disconnected.");
   tx_done_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s.tx_st == uri_pkg::TX_STOP && tx_end && on |=> s.evt[uri_pkg::EV_TX_DONE])
      else $error("Transmit-done event missing after stop bit.");
   rx_move_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      !s.rxb_full && s.cnt != 3'h0 && !bus_in.rd |=> s.rxb_full && s.evt[uri_pkg::EV_RX_RDY])
      else $error("FIFO byte not moved to the receive register.");
   fifo_cap_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s.cnt <= uri_pkg::FIFO_DEPTH)
      else $error("Receive FIFO count above six.");
   frame_err_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s.rx_st == uri_pkg::RX_STOP && rx_end && !rx_in && on |=> s.err[uri_pkg::ERR_FRM])
      else $error("Missing stop bit not flagged.");
endmodule

// ===== tb/uri_peer.sv
// Purpose: Remote serial transceiver on the far side of the port's line pins.
// Assumes: Fixed bit time in system clocks; the line idles high.
// Notes: The bench calls send; the receiver runs on its own.
`timescale 1ns/10ps
module uri_peer #(parameter int BIT = 200) (
   input wire logic clk_sys_in,
   input wire logic line_in,
   input wire logic par_in,
   output logic line_out,
   output logic got_out,
   output logic [8:0] word_out
);
   logic [7:0] d;
   logic p;
   initial begin
      line_out = 1'b1;
      got_out = 1'b0;
      word_out = '0;
      forever begin
         @(posedge clk_sys_in);
         got_out <= 1'b0;
         if (line_in === 1'b0) begin
            // Sampling mid-bit rides out the tick jitter of the rate generator.
            repeat (BIT / 2) @(posedge clk_sys_in);
            for (int i = 0; i < 8; i++) begin
               repeat (BIT) @(posedge clk_sys_in);
               d[i] = line_in;
            end
            p = 1'b0;
            if (par_in) begin
               repeat (BIT) @(posedge clk_sys_in);
               p = line_in;
            end
            repeat (BIT) @(posedge clk_sys_in);
            word_out <= {line_in && !(par_in && (^{d, p})), d};
            got_out <= 1'b1;
         end
      end
   end
   // Bad flips the parity bit, stop sets the stop level, lo keeps the line low after.
   task automatic send(input logic [7:0] b, input logic par, input logic bad,
                       input logic stop, input int lo);
      logic [10:0] f;
      f = {stop, (^b) ^ bad, b, 1'b0};
      if (!par) f[9] = stop;
      for (int i = 0; i < (par ? 11 : 10) + lo; i++) begin
         @(posedge clk_sys_in);
         line_out <= (i < 11) ? f[i] : 1'b0;
         repeat (BIT - 1) @(posedge clk_sys_in);
      end
      @(posedge clk_sys_in);
      line_out <= 1'b1;
   endtask
endmodule

// ===== tb/uri_top_test.sv
// Purpose: Self-checking bench of the serial port register block.
// Assumes: Rate code of one megabaud, so 200 clocks per bit.
// Notes: Read data and received frames are checked against queued notes.
`timescale 1ns/10ps
module uri_top_test;
   localparam int BIT = 200;
   logic clk_sys_in;
   logic nrst_in;
   uri_pkg::uri_bus_s bus;
   logic [31:0] rdata_out;
   logic [31:0] pin_in;
   uri_pkg::uri_pins_s pins_out;
   logic irq_out;
   logic line_p, got_p, par_on, tx_line;
   logic rd_d = 1'b0;
   logic [8:0] word_p;
   logic [31:0] m, v;
   logic [7:0] b1, b2;
   logic [31:0] rq[$];
   logic [8:0] tq[$];
   int n_fail = 0;
   int checks = 0;
   logic [11:0] ra[10] = '{uri_pkg::OFF_IRQ_MASK, uri_pkg::OFF_ERR_CAUSE, uri_pkg::OFF_PORT_EN,
      uri_pkg::OFF_HS_OUT_PIN, uri_pkg::OFF_SER_OUT_PIN, uri_pkg::OFF_HS_IN_PIN,
      uri_pkg::OFF_SER_IN_PIN, uri_pkg::OFF_LINE_RATE, uri_pkg::OFF_LINE_SETUP, 12'h004};
   logic [31:0] rv[10] = '{32'h0, 32'h0, 32'h0, uri_pkg::PIN_NONE, uri_pkg::PIN_NONE,
      uri_pkg::PIN_NONE, uri_pkg::PIN_NONE, uri_pkg::RATE_RST, 32'h0, 32'h0};
   logic [31:0] rc[3] = '{32'h0004_F000, 32'h01D7_E000, 32'h0EBE_DFA4};
   logic [31:0] ec[3] = '{32'h2, 32'h4, 32'hC};

   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   uri_top DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bus_in(bus),
      .rdata_out(rdata_out), .pin_in(pin_in), .pins_out(pins_out), .irq_out(irq_out));
   uri_peer #(.BIT(BIT)) peer (.clk_sys_in(clk_sys_in), .line_in(tx_line), .par_in(par_on),
      .line_out(line_p), .got_out(got_p), .word_out(word_p));
   // The serial line has a pull-up, so a released pin reads as idle.
   assign tx_line = pins_out.oe[3] ? pins_out.drv[3] : 1'b1;
   assign pin_in = {26'h3FF_FFFF, line_p, 5'h1F};

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk_sys_in);
      rq.push_back(e);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
   endtask
   task automatic idle();
      @(posedge clk_sys_in);
      bus <= '0;
   endtask
   task automatic wait_irq();
      @(negedge clk_sys_in);
      for (int i = 0; i < 30 * BIT && irq_out !== 1'b1; i++) @(negedge clk_sys_in);
      check(irq_out, 32'h1);
   endtask
   task automatic close_out();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      rd_d <= bus.rd;
      if (rd_d === 1'b1) check(rdata_out, rq.pop_front());
      if (got_p === 1'b1) check(word_p, tq.pop_front());
   end

   initial begin
      repeat (60000) @(posedge clk_sys_in);
      n_fail++;
      close_out();
   end

   initial begin
      nrst_in = 1'b0;
      bus = '0;
      par_on = 1'b0;
      v = $urandom(27);
      repeat (12) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      @(negedge clk_sys_in);
      check(pins_out.oe, 32'h0);
      for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
      v = $urandom;
      m = v & uri_pkg::EV_MASK;
      wr(uri_pkg::OFF_IRQ_SET, v);
      wr(uri_pkg::OFF_IRQ_SET, 32'h0);
      rd(uri_pkg::OFF_IRQ_SET, m);
      v = $urandom;
      m = m & ~v;
      wr(uri_pkg::OFF_IRQ_CLR, v);
      wr(uri_pkg::OFF_IRQ_CLR, 32'h0);
      rd(uri_pkg::OFF_IRQ_CLR, m);
      rd(uri_pkg::OFF_IRQ_MASK, m);
      wr(uri_pkg::OFF_IRQ_CLR, 32'hFFFF_FFFF);
      for (int i = 0; i < 3; i++) begin
         wr(uri_pkg::OFF_LINE_RATE, rc[i]);
         rd(uri_pkg::OFF_LINE_RATE, rc[i]);
      end
      wr(uri_pkg::OFF_LINE_RATE, 32'h1000_0000);
      wr(uri_pkg::OFF_SER_OUT_PIN, 32'h3);
      wr(uri_pkg::OFF_SER_IN_PIN, 32'h5);
      idle();
      $display("test registers done");
      // A bad frame while disabled must leave no trace.
      peer.send(8'h33, 1'b0, 1'b0, 1'b0, 0);
      @(negedge clk_sys_in);
      check(pins_out.oe, 32'h0);
      rd(uri_pkg::OFF_ERR_CAUSE, 32'h0);
      wr(uri_pkg::OFF_PORT_EN, {29'h0, uri_pkg::EN_ON});
      idle();
      @(negedge clk_sys_in);
      check({pins_out.oe[3], pins_out.drv[3]}, 32'h3);
      wr(uri_pkg::OFF_SER_OUT_PIN, uri_pkg::PIN_NONE);
      idle();
      @(negedge clk_sys_in);
      check(pins_out.oe, 32'h0);
      wr(uri_pkg::OFF_SER_OUT_PIN, 32'h3);
      wr(uri_pkg::OFF_IRQ_SET, 32'h80);
      $display("test pins done");
      for (int k = 0; k < 2; k++) begin
         par_on <= k[0];
         wr(uri_pkg::OFF_LINE_SETUP, k[0] ? 32'hE : 32'h0);
         b1 = 8'($urandom);
         tq.push_back({1'b1, b1});
         wr(uri_pkg::OFF_TX_BYTE, {24'h0, b1});
         idle();
         wait_irq();
         wr(uri_pkg::OFF_EVT_STAT, 32'h80);
         idle();
         @(negedge clk_sys_in);
         check(irq_out, 32'h0);
      end
      $display("test transmit done");
      // Flow control on with the handshake input held high: the byte must wait.
      par_on <= 1'b0;
      wr(uri_pkg::OFF_LINE_SETUP, 32'h1);
      wr(uri_pkg::OFF_HS_IN_PIN, 32'h4);
      tq.push_back(9'h1A5);
      wr(uri_pkg::OFF_TX_BYTE, 32'hA5);
      idle();
      repeat (12 * BIT) @(posedge clk_sys_in);
      rd(uri_pkg::OFF_EVT_STAT, 32'h2);
      wr(uri_pkg::OFF_HS_IN_PIN, uri_pkg::PIN_NONE);
      idle();
      wait_irq();
      rd(uri_pkg::OFF_EVT_STAT, 32'h83);
      wr(uri_pkg::OFF_EVT_STAT, 32'h83);
      wr(uri_pkg::OFF_LINE_SETUP, 32'hE);
      par_on <= 1'b1;
      $display("test flow control done");
      wr(uri_pkg::OFF_IRQ_CLR, 32'h80);
      wr(uri_pkg::OFF_IRQ_SET, 32'h4);
      idle();
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      peer.send(b1, 1'b1, 1'b0, 1'b1, 0);
      peer.send(b2, 1'b1, 1'b0, 1'b1, 0);
      wait_irq();
      wr(uri_pkg::OFF_EVT_STAT, 32'h4);
      rd(uri_pkg::OFF_RX_BYTE, {24'h0, b1});
      idle();
      wait_irq();
      wr(uri_pkg::OFF_EVT_STAT, 32'h4);
      rd(uri_pkg::OFF_RX_BYTE, {24'h0, b2});
      idle();
      @(negedge clk_sys_in);
      check(irq_out, 32'h0);
      $display("test receive done");
      // Bad parity, bad stop, then a line held low well past one frame.
      for (int k = 0; k < 3; k++) begin
         peer.send(k == 2 ? 8'h00 : 8'h5A, 1'b1, k == 0, k == 0, k == 2 ? 12 : 0);
         repeat (2 * BIT) @(posedge clk_sys_in);
         rd(uri_pkg::OFF_ERR_CAUSE, ec[k]);
         wr(uri_pkg::OFF_ERR_CAUSE, 32'h0);
         rd(uri_pkg::OFF_ERR_CAUSE, ec[k]);
         wr(uri_pkg::OFF_ERR_CAUSE, ec[k]);
         rd(uri_pkg::OFF_ERR_CAUSE, 32'h0);
         idle();
      end
      $display("test errors done");
      wr(uri_pkg::OFF_PORT_EN, 32'h0);
      idle();
      @(negedge clk_sys_in);
      check(pins_out.oe, 32'h0);
      $display("test disable done");
      close_out();
   end
endmodule
